// >>> sbl_host_model.sv
`timescale 1ns/100ps
module sbl_host_model (
  input wire logic i_clock,
  input wire logic i_line,
  output logic o_rxd
);
  int bit_clks = sbl_pkg::PRESCALE * sbl_pkg::DIVIDER * sbl_pkg::OVERSAMPLE * sbl_pkg::BUS_DIV;
  logic [7:0] rx_q[$];
  logic break_seen = 1'b0;
  initial o_rxd = 1'b1;
  // 8n1, lsb first; call just after a rising edge
  task automatic send_byte(input logic [7:0] b);
    logic [9:0] frame;
    frame = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      o_rxd <= frame[i];
      repeat (bit_clks) @(posedge i_clock);
    end
  endtask
  // a low stop bit marks a break rather than a character
  initial begin
    logic [7:0] d;
    forever begin
      @(negedge i_line);
      repeat (bit_clks / 2) @(posedge i_clock);
      if (!i_line) begin
        for (int i = 0; i < 8; i++) begin
          repeat (bit_clks) @(posedge i_clock);
          d[i] = i_line;
        end
        repeat (bit_clks) @(posedge i_clock);
        if (i_line) rx_q.push_back(d);
        else break_seen = 1'b1;
      end
    end
  end
endmodule

// >>> sbl_loader.sv
`timescale 1ns/100ps
// Function
// - after reset start serial unit at 7812 baud, receiver and transmitter on
// - set port wired-OR bit so transmit pin only drives low
// - send one break character before waiting for the first character
// - first character $00 jumps straight to EEPROM at $B600
// - first character $FF keeps default rate
// - first character $E0 or $C0 selects 1200 baud and longer timeout
// - RAM store pointer starts at $0000
// - variable download up to 512 bytes, ended by four idle characters
// - 256-byte RAM variant takes exactly 256 bytes after $FF
// - default timeout is 539 passes of 19 cycles, ended early by arrivals
// - bit time is 16 serial clocks, prescaler 4, divider 4, 10 bits
// - timeout starts after the first $FF and restarts at each byte
// - $FF alone times out and jumps to RAM with nothing stored
// - store each byte, echo it, advance pointer while inside RAM
// - on timeout or full RAM preset index registers and jump to RAM
// - upload sends successive memory bytes forever from caller address
// - write routine starts at $BF00, programs from $D000 by default only after the jump to RAM presets the index registers
// - write routine first sends $FF as ready
// - program byte, wait, read back, echo verify, wait for next
// - count, start address and program time may be overridden
module sbl_loader (
  input wire logic i_clock,
  input wire logic i_reset_n,
  input wire logic i_rxd,
  input wire logic i_small_ram,
  input wire logic i_run_upload,
  input wire logic i_run_program,
  input wire logic [15:0] i_user_addr,
  input wire logic i_user_valid,
  input wire logic [15:0] i_prog_count,
  input wire logic [15:0] i_prog_time,
  input wire logic [15:0] i_prog_addr,
  input wire logic i_prog_override,
  input wire logic [7:0] i_mem_rdata,
  output logic o_txd_out,
  output logic o_txd_oe,
  output logic o_port_wired_or_bit,
  output logic o_mem_we,
  output logic o_mem_re,
  output logic [15:0] o_mem_addr,
  output logic [7:0] o_mem_wdata,
  output logic o_jump,
  output logic [15:0] o_jump_addr,
  output logic [15:0] o_index_x,
  output logic [15:0] o_index_y,
  output logic o_slow_baud
);
  sbl_ser_if ser ();
  sbl_pkg::sbl_state_t state;
  logic [7:0] bus_cnt;
  logic bus_en;
  logic txd_raw;
  logic [15:0] delay_const;
  logic [15:0] delay_cnt;
  logic [4:0] loop_cnt;
  logic timer_on;
  logic timeout;
  logic [15:0] ptr;
  logic [15:0] prog_left;
  logic [15:0] prog_wait;
  logic [15:0] prog_time;
  logic [7:0] rx_hold;
  logic rx_pend;
  logic tx_sent;

  sbl_serial u_serial (
    .i_clock(i_clock),
    .i_reset_n(i_reset_n),
    .i_bus_en(bus_en),
    .i_rxd(i_rxd),
    .o_txd(txd_raw),
    .ser(ser)
  );

  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      bus_cnt <= 8'h00;
      bus_en <= 1'b0;
    end else begin
      bus_en <= (bus_cnt == 8'(sbl_pkg::BUS_DIV - 1));
      bus_cnt <= (bus_cnt == 8'(sbl_pkg::BUS_DIV - 1)) ? 8'h00 : bus_cnt + 8'h01;
    end
  end

  // wired-or pin: drive only low, pull-up supplies the high
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_txd_out <= 1'b0;
      o_txd_oe <= 1'b0;
      o_port_wired_or_bit <= 1'b0;
    end else begin
      o_port_wired_or_bit <= 1'b1;
      o_txd_out <= 1'b0;
      o_txd_oe <= !txd_raw;
    end
  end

  // one character of look-ahead, so a byte queued during programming waits
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rx_pend <= 1'b0;
      rx_hold <= 8'h00;
    end else if (ser.rx_valid) begin
      rx_pend <= 1'b1;
      rx_hold <= ser.rx_data;
    end else if (state == sbl_pkg::SBL_FIRST || state == sbl_pkg::SBL_LOAD ||
                 state == sbl_pkg::SBL_PWAIT) begin
      rx_pend <= 1'b0;
    end
  end

  // idle timer: 19-cycle passes counted down from the delay constant
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      delay_cnt <= 16'h0000;
      loop_cnt <= 5'h00;
      timeout <= 1'b0;
    end else if (!timer_on || rx_pend) begin
      delay_cnt <= delay_const;
      loop_cnt <= 5'h00;
      timeout <= 1'b0;
    end else if (bus_en && !timeout) begin
      if (loop_cnt == 5'(sbl_pkg::LOOP_CYCLES - 1)) begin
        loop_cnt <= 5'h00;
        delay_cnt <= delay_cnt - 16'h0001;
        if (delay_cnt == 16'h0001) begin
          timeout <= 1'b1;
        end
      end else begin
        loop_cnt <= loop_cnt + 5'h01;
      end
    end
  end

  // the wait starts as soon as a byte is taken, so it also runs during its echo
  always_comb begin
    timer_on = (state == sbl_pkg::SBL_LOAD || state == sbl_pkg::SBL_ECHO);
  end

  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state <= sbl_pkg::SBL_INIT;
      ser.tick_div <= sbl_pkg::TICK_FAST;
      ser.tx_start <= 1'b0;
      ser.tx_break <= 1'b0;
      ser.tx_data <= 8'h00;
      delay_const <= sbl_pkg::DELAY_FAST;
      o_slow_baud <= 1'b0;
      ptr <= 16'h0000;
      tx_sent <= 1'b0;
      prog_left <= 16'h0000;
      prog_wait <= 16'h0000;
      prog_time <= 16'h0000;
      o_mem_we <= 1'b0;
      o_mem_re <= 1'b0;
      o_mem_addr <= 16'h0000;
      o_mem_wdata <= 8'h00;
      o_jump <= 1'b0;
      o_jump_addr <= 16'h0000;
      o_index_x <= 16'h0000;
      o_index_y <= 16'h0000;
    end else begin
      ser.tx_start <= 1'b0;
      o_mem_we <= 1'b0;
      o_mem_re <= 1'b0;
      o_jump <= 1'b0;
      unique case (state)
        sbl_pkg::SBL_INIT: begin
          ser.tick_div <= sbl_pkg::TICK_FAST;
          delay_const <= sbl_pkg::DELAY_FAST;
          o_slow_baud <= 1'b0;
          ser.tx_break <= 1'b1;
          ser.tx_start <= 1'b1;
          tx_sent <= 1'b0;
          state <= sbl_pkg::SBL_BREAK;
        end
        sbl_pkg::SBL_BREAK: begin
          tx_sent <= 1'b1;
          if (tx_sent && !ser.tx_busy) begin
            ser.tx_break <= 1'b0;
            state <= sbl_pkg::SBL_FIRST;
          end
        end
        sbl_pkg::SBL_FIRST: begin
          if (rx_pend) begin
            ptr <= sbl_pkg::ADDR_RAM;
            if (rx_hold == sbl_pkg::CHAR_BREAK) begin
              o_jump_addr <= sbl_pkg::ADDR_EEPROM;
              o_jump <= 1'b1;
              state <= sbl_pkg::SBL_IDLE;
            end else if (rx_hold == sbl_pkg::CHAR_SLOW_A ||
                         rx_hold == sbl_pkg::CHAR_SLOW_B) begin
              ser.tick_div <= sbl_pkg::TICK_SLOW;
              delay_const <= sbl_pkg::DELAY_SLOW;
              o_slow_baud <= 1'b1;
              state <= sbl_pkg::SBL_LOAD;
            end else begin
              state <= sbl_pkg::SBL_LOAD;
            end
          end
        end
        sbl_pkg::SBL_LOAD: begin
          if (rx_pend) begin
            o_mem_addr <= ptr;
            o_mem_wdata <= rx_hold;
            o_mem_we <= 1'b1;
            ser.tx_data <= rx_hold;
            ser.tx_start <= 1'b1;
            ptr <= ptr + 16'h0001;
            tx_sent <= 1'b0;
            state <= sbl_pkg::SBL_ECHO;
          end else if (timeout && !i_small_ram) begin
            state <= sbl_pkg::SBL_JUMP;
          end
        end
        sbl_pkg::SBL_ECHO: begin
          tx_sent <= 1'b1;
          if (tx_sent && !ser.tx_busy) begin
            if (ptr == (i_small_ram ? sbl_pkg::RAM_FULL_256 : sbl_pkg::RAM_FULL_512)) begin
              state <= sbl_pkg::SBL_JUMP;
            end else begin
              state <= sbl_pkg::SBL_LOAD;
            end
          end
        end
        sbl_pkg::SBL_JUMP: begin
          o_index_x <= sbl_pkg::PROG_COUNT_DEF;
          o_index_y <= sbl_pkg::ADDR_EPROM;
          o_jump_addr <= sbl_pkg::ADDR_RAM;
          o_jump <= 1'b1;
          state <= sbl_pkg::SBL_IDLE;
        end
        sbl_pkg::SBL_IDLE: begin
          // the loaded program enters a utility by raising one of these
          if (i_run_program) begin
            o_jump_addr <= sbl_pkg::ADDR_PROG;
            prog_left <= i_prog_override ? i_prog_count : o_index_x;
            ptr <= i_prog_override ? i_prog_addr : o_index_y;
            prog_time <= i_prog_override ? i_prog_time : sbl_pkg::PROG_TIME_DEF;
            ser.tx_data <= sbl_pkg::CHAR_SYNC;
            ser.tx_start <= 1'b1;
            tx_sent <= 1'b0;
            state <= sbl_pkg::SBL_PREADY;
          end else if (i_run_upload && i_user_valid) begin
            ptr <= i_user_addr;
            state <= sbl_pkg::SBL_UREAD;
          end
        end
        sbl_pkg::SBL_PREADY: begin
          tx_sent <= 1'b1;
          if (tx_sent && !ser.tx_busy) begin
            state <= sbl_pkg::SBL_PWAIT;
          end
        end
        sbl_pkg::SBL_PWAIT: begin
          // stays here until reset once the count is spent
          if (rx_pend && prog_left != 16'h0000) begin
            o_mem_addr <= ptr;
            o_mem_wdata <= rx_hold;
            o_mem_we <= 1'b1;
            prog_wait <= prog_time;
            state <= sbl_pkg::SBL_PBURN;
          end
        end
        sbl_pkg::SBL_PBURN: begin
          if (bus_en) begin
            if (prog_wait == 16'h0000) begin
              o_mem_re <= 1'b1;
              state <= sbl_pkg::SBL_PREAD;
            end else begin
              prog_wait <= prog_wait - 16'h0001;
            end
          end
        end
        sbl_pkg::SBL_PREAD: begin
          // read data arrives one cycle after the read strobe
          if (!o_mem_re) begin
            ser.tx_data <= i_mem_rdata;
            ser.tx_start <= 1'b1;
            tx_sent <= 1'b0;
            ptr <= ptr + 16'h0001;
            prog_left <= prog_left - 16'h0001;
            state <= sbl_pkg::SBL_PSEND;
          end
        end
        sbl_pkg::SBL_PSEND: begin
          tx_sent <= 1'b1;
          if (tx_sent && !ser.tx_busy) begin
            state <= sbl_pkg::SBL_PWAIT;
          end
        end
        sbl_pkg::SBL_UREAD: begin
          o_mem_addr <= ptr;
          o_mem_re <= 1'b1;
          tx_sent <= 1'b0;
          state <= sbl_pkg::SBL_USEND;
        end
        sbl_pkg::SBL_USEND: begin
          if (!tx_sent && !o_mem_re) begin
            ser.tx_data <= i_mem_rdata;
            ser.tx_start <= 1'b1;
            tx_sent <= 1'b1;
          end else if (tx_sent && !ser.tx_start && !ser.tx_busy) begin
            ptr <= ptr + 16'h0001;
            state <= sbl_pkg::SBL_UREAD;
          end
        end
        default: state <= sbl_pkg::SBL_INIT;
      endcase
    end
  end
endmodule

// >>> sbl_loader_monitor.sv
`timescale 1ns/100ps
module sbl_loader_monitor (
  input wire logic i_clock,
  input wire logic i_reset_n,
  input wire logic i_prog_override,
  input wire logic [15:0] i_prog_addr,
  input wire logic o_txd_out,
  input wire logic o_txd_oe,
  input wire logic o_port_wired_or_bit,
  input wire logic o_mem_we,
  input wire logic [15:0] o_mem_addr,
  input wire logic o_jump,
  input wire logic [15:0] o_jump_addr,
  input wire logic [15:0] o_index_x,
  input wire logic [15:0] o_index_y,
  input wire logic o_slow_baud
);
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (!i_reset_n);
  logic [12:0] since_rst;
  logic oe_seen;
  logic have_we;
  logic jumped;
  logic [15:0] last_addr;
  // the break waits for the first sample tick, so allow well over one tick time
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      since_rst <= '0;
      oe_seen <= 1'b0;
    end else begin
      if (since_rst != 13'h1FFF) since_rst <= since_rst + 13'h0001;
      if (o_txd_oe) oe_seen <= 1'b1;
    end
  end
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      have_we <= 1'b0;
      jumped <= 1'b0;
      last_addr <= '0;
    end else if (o_jump) begin
      have_we <= 1'b0;
      jumped <= 1'b1;
    end else if (o_mem_we) begin
      have_we <= 1'b1;
      last_addr <= o_mem_addr;
    end
  end
  wired_or_on_a: assert property ($past(i_reset_n) |-> o_port_wired_or_bit)
    else $error("wired-or bit low after reset");
  txd_low_only_a: assert property (o_txd_out == 1'b0)
    else $error("transmit pin driven high");
  break_start_a: assert property (since_rst == 13'h1388 |-> oe_seen)
    else $error("no break after reset");
  jump_target_a: assert property (o_jump |-> o_jump_addr inside {16'hB600, 16'h0000})
    else $error("jump to unexpected address");
  jump_pulse_a: assert property (o_jump |=> !o_jump)
    else $error("jump pulse too long");
  we_pulse_a: assert property (o_mem_we |=> !o_mem_we)
    else $error("store pulse too long");
  ptr_step_a: assert property (o_mem_we && have_we |-> o_mem_addr == last_addr + 16'h0001)
    else $error("store pointer did not step by one");
  first_addr_a: assert property (o_mem_we && !have_we |-> o_mem_addr == (jumped ?
    (i_prog_override ? i_prog_addr : sbl_pkg::ADDR_EPROM) : sbl_pkg::ADDR_RAM))
    else $error("first store at wrong address");
  index_preset_a: assert property (o_jump && o_jump_addr == 16'h0000 && !i_prog_override
    |-> o_index_x == sbl_pkg::PROG_COUNT_DEF && o_index_y == sbl_pkg::ADDR_EPROM)
    else $error("index registers not preset at jump");
  slow_hold_a: assert property (o_slow_baud |=> o_slow_baud)
    else $error("slow rate dropped");
  cover property (o_jump && o_jump_addr == sbl_pkg::ADDR_EEPROM);
  cover property ($rose(o_slow_baud));
  cover property (o_mem_we && jumped);
endmodule
bind sbl_loader sbl_loader_monitor sbl_loader_monitor_inst (.i_clock, .i_reset_n,
  .i_prog_override, .i_prog_addr, .o_txd_out, .o_txd_oe, .o_port_wired_or_bit, .o_mem_we,
  .o_mem_addr, .o_jump, .o_jump_addr, .o_index_x, .o_index_y, .o_slow_baud);

// >>> sbl_pkg.sv
package sbl_pkg;
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned BUS_HZ = 2_000_000;
  // bus-clock enable: one pulse per emulated bus cycle
  localparam int unsigned BUS_DIV = CLK_HZ / BUS_HZ;
  localparam int unsigned BAUD_FAST = 7812;
  localparam int unsigned BAUD_SLOW = 1200;
  localparam int unsigned PRESCALE = 4;
  localparam int unsigned DIVIDER = 4;
  localparam int unsigned OVERSAMPLE = 16;
  localparam int unsigned BITS_PER_CHAR = 10;
  // 16x sample tick in bus cycles: 4*4 at the fast rate, 4*26 at the slow one
  localparam logic [7:0] TICK_FAST = 8'(PRESCALE * DIVIDER);
  localparam logic [7:0] TICK_SLOW = 8'(PRESCALE * 26);
  localparam int unsigned LOOP_CYCLES = 19;
  localparam logic [15:0] DELAY_FAST = 16'h021B;
  // slow timeout kept just over four character times, as at the fast rate
  localparam logic [15:0] DELAY_SLOW = 16'h0DB0;
  localparam logic [7:0] CHAR_BREAK = 8'h00;
  localparam logic [7:0] CHAR_SYNC = 8'hFF;
  localparam logic [7:0] CHAR_SLOW_A = 8'hE0;
  localparam logic [7:0] CHAR_SLOW_B = 8'hC0;
  localparam logic [15:0] ADDR_EEPROM = 16'hB600;
  localparam logic [15:0] ADDR_RAM = 16'h0000;
  localparam logic [15:0] ADDR_PROG = 16'hBF00;
  localparam logic [15:0] ADDR_EPROM = 16'hD000;
  localparam logic [15:0] RAM_FULL_512 = 16'h0200;
  localparam logic [15:0] RAM_FULL_256 = 16'h0100;
  localparam logic [15:0] PROG_COUNT_DEF = 16'h3000;
  localparam logic [15:0] PROG_TIME_DEF = 16'h0FA0;
  typedef enum logic [3:0] {
    SBL_INIT = 4'h0,
    SBL_BREAK = 4'h1,
    SBL_FIRST = 4'h2,
    SBL_LOAD = 4'h3,
    SBL_ECHO = 4'h4,
    SBL_JUMP = 4'h5,
    SBL_PREADY = 4'h6,
    SBL_PWAIT = 4'h7,
    SBL_PBURN = 4'h8,
    SBL_PREAD = 4'h9,
    SBL_PSEND = 4'hA,
    SBL_UREAD = 4'hB,
    SBL_USEND = 4'hC,
    SBL_IDLE = 4'hD
  } sbl_state_t;
endpackage

// >>> sbl_ser_if.sv
`timescale 1ns/100ps
interface sbl_ser_if;
  logic [7:0] tick_div;
  logic tx_start;
  logic tx_break;
  logic [7:0] tx_data;
  logic tx_busy;
  logic rx_valid;
  logic [7:0] rx_data;
  modport ctrl (output tick_div, output tx_start, output tx_break, output tx_data,
    input tx_busy, input rx_valid, input rx_data);
  modport unit (input tick_div, input tx_start, input tx_break, input tx_data,
    output tx_busy, output rx_valid, output rx_data);
endinterface

// >>> sbl_serial.sv
`timescale 1ns/100ps
module sbl_serial (
  input wire logic i_clock,
  input wire logic i_reset_n,
  input wire logic i_bus_en,
  input wire logic i_rxd,
  output logic o_txd,
  sbl_ser_if.unit ser
);
  logic [7:0] tick_cnt;
  logic tick;
  logic [3:0] tx_sub;
  logic [3:0] tx_bit;
  logic [9:0] tx_shift;
  logic [3:0] rx_sub;
  logic [3:0] rx_bit;
  logic [7:0] rx_shift;
  logic rx_active;

  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      tick_cnt <= 8'h00;
      tick <= 1'b0;
    end else begin
      tick <= 1'b0;
      if (i_bus_en) begin
        if (tick_cnt + 8'h01 >= ser.tick_div) begin
          tick_cnt <= 8'h00;
          tick <= 1'b1;
        end else begin
          tick_cnt <= tick_cnt + 8'h01;
        end
      end
    end
  end

  // 16 ticks per bit, 10 bits per character
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      tx_sub <= 4'h0;
      tx_bit <= 4'h0;
      tx_shift <= 10'h3FF;
      ser.tx_busy <= 1'b0;
      o_txd <= 1'b1;
    end else if (ser.tx_start && !ser.tx_busy) begin
      tx_shift <= ser.tx_break ? 10'h000 : {1'b1, ser.tx_data, 1'b0};
      tx_sub <= 4'h0;
      tx_bit <= 4'h0;
      ser.tx_busy <= 1'b1;
    end else if (ser.tx_busy && tick) begin
      o_txd <= tx_shift[0];
      tx_sub <= tx_sub + 4'h1;
      if (tx_sub == 4'hF) begin
        tx_shift <= {1'b1, tx_shift[9:1]};
        tx_bit <= tx_bit + 4'h1;
        if (tx_bit == 4'(sbl_pkg::BITS_PER_CHAR - 1)) begin
          ser.tx_busy <= 1'b0;
          o_txd <= 1'b1;
        end
      end
    end
  end

  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rx_active <= 1'b0;
      rx_sub <= 4'h0;
      rx_bit <= 4'h0;
      rx_shift <= 8'h00;
      ser.rx_valid <= 1'b0;
      ser.rx_data <= 8'h00;
    end else begin
      ser.rx_valid <= 1'b0;
      if (tick) begin
        if (!rx_active) begin
          if (!i_rxd) begin
            rx_active <= 1'b1;
            rx_sub <= 4'h0;
            rx_bit <= 4'h0;
          end
        end else begin
          rx_sub <= rx_sub + 4'h1;
          if (rx_sub == 4'h7) begin
            // centre of each bit; false start bits are dropped
            if (rx_bit == 4'h0 && i_rxd) begin
              rx_active <= 1'b0;
            end else if (rx_bit == 4'h9) begin
              rx_active <= 1'b0;
              ser.rx_valid <= 1'b1;
              ser.rx_data <= rx_shift;
            end else if (rx_bit != 4'h0) begin
              rx_shift <= {i_rxd, rx_shift[7:1]};
            end
          end
          if (rx_sub == 4'hF) begin
            rx_bit <= rx_bit + 4'h1;
          end
        end
      end
    end
  end
endmodule

// >>> tb_top.sv
`timescale 1ns/100ps
`define CHK(nm, exp, got) \
  begin \
    num_checks++; \
    if ((got) !== (exp)) begin \
      failures++; \
      $display("wrong value %s expected %h seen %h", nm, exp, got); \
    end \
  end
module tb_top;
  logic i_clock;
  logic i_reset_n;
  logic run_program;
  logic run_upload;
  logic user_valid;
  logic [15:0] user_addr;
  logic prog_override;
  logic [15:0] prog_time;
  logic [15:0] prog_addr;
  logic [7:0] mem_rdata;
  logic rxd;
  logic txd_out, txd_oe, wor_bit, mem_we, mem_re, jump, slow;
  logic [15:0] mem_addr, jump_addr, idx_x, idx_y, jmp_a;
  logic [7:0] mem_wdata;
  int failures, num_checks, cyc, jmp_n, jmp_t;
  logic [15:0] wr_a[$];
  logic [7:0] wr_d[$];
  // wired-or pin: released means pulled up
  wire logic line = txd_oe ? txd_out : 1'b1;
  sbl_loader sbl_loader_inst (.i_clock(i_clock), .i_reset_n(i_reset_n), .i_rxd(rxd),
    .i_small_ram(1'b0), .i_run_upload(run_upload), .i_run_program(run_program),
    .i_user_addr(user_addr), .i_user_valid(user_valid), .i_prog_count(16'h0004),
    .i_prog_time(prog_time), .i_prog_addr(prog_addr), .i_prog_override(prog_override),
    .i_mem_rdata(mem_rdata), .o_txd_out(txd_out), .o_txd_oe(txd_oe),
    .o_port_wired_or_bit(wor_bit), .o_mem_we(mem_we), .o_mem_re(mem_re),
    .o_mem_addr(mem_addr), .o_mem_wdata(mem_wdata), .o_jump(jump), .o_jump_addr(jump_addr),
    .o_index_x(idx_x), .o_index_y(idx_y), .o_slow_baud(slow));
  sbl_host_model sbl_host_model_inst (.i_clock(i_clock), .i_line(line), .o_rxd(rxd));
  initial begin
    i_clock = 1'b0;
    forever #5 i_clock = ~i_clock;
  end
  always @(posedge i_clock) begin
    cyc++;
    if (mem_we === 1'b1) begin
      wr_a.push_back(mem_addr);
      wr_d.push_back(mem_wdata);
    end
    if (jump === 1'b1) begin
      jmp_a = jump_addr;
      jmp_t = cyc;
      jmp_n++;
    end
    if (mem_re === 1'b1) mem_rdata <= mem_addr[7:0] ^ 8'h5A;
  end
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic do_reset;
    i_reset_n <= 1'b0;
    repeat (8) @(posedge i_clock);
    wr_a.delete();
    wr_d.delete();
    jmp_n = 0;
    sbl_host_model_inst.rx_q.delete();
    sbl_host_model_inst.break_seen = 1'b0;
    i_reset_n <= 1'b1;
    for (int i = 0; i < 200000 && !sbl_host_model_inst.break_seen; i++) @(posedge i_clock);
    `CHK("break", 1'b1, sbl_host_model_inst.break_seen)
    `CHK("wired_or", 1'b1, wor_bit)
    `CHK("slow_baud", 1'b0, slow)
    repeat (sbl_host_model_inst.bit_clks) @(posedge i_clock);
  endtask
  task automatic wait_rx(input int n);
    for (int i = 0; i < 400000 && sbl_host_model_inst.rx_q.size() < n; i++) @(posedge i_clock);
  endtask
  task automatic test_eeprom_jump;
    do_reset();
    sbl_host_model_inst.send_byte(8'h00);
    for (int i = 0; i < 20000 && jmp_n == 0; i++) @(posedge i_clock);
    `CHK("jump_count", 1, jmp_n)
    `CHK("jump_addr", sbl_pkg::ADDR_EEPROM, jmp_a)
    `CHK("writes", 0, wr_a.size())
    $display("eeprom jump test done");
  endtask
  task automatic test_slow_rate;
    logic [7:0] firsts[2];
    firsts = '{sbl_pkg::CHAR_SLOW_A, sbl_pkg::CHAR_SLOW_B};
    foreach (firsts[k]) begin
      do_reset();
      sbl_host_model_inst.send_byte(firsts[k]);
      repeat (3200) @(posedge i_clock);
      `CHK("slow_baud", 1'b1, slow)
      `CHK("jump_count", 0, jmp_n)
    end
    $display("slow rate test done");
  endtask
  task automatic test_load;
    int t0;
    int exp_to;
    logic [7:0] dat[2];
    dat = '{8'hA5, 8'h3C};
    exp_to = int'(sbl_pkg::DELAY_FAST) * sbl_pkg::LOOP_CYCLES * sbl_pkg::BUS_DIV;
    do_reset();
    sbl_host_model_inst.send_byte(sbl_pkg::CHAR_SYNC);
    foreach (dat[k]) begin
      sbl_host_model_inst.send_byte(dat[k]);
      t0 = cyc;
      wait_rx(k + 1);
      `CHK("echo", dat[k], sbl_host_model_inst.rx_q[k])
      `CHK("store_addr", sbl_pkg::ADDR_RAM + 16'(k), wr_a[k])
      `CHK("store_data", dat[k], wr_d[k])
    end
    // the count starts once the last byte is taken, near its stop bit
    for (int i = 0; i < 600000 && jmp_n == 0; i++) @(posedge i_clock);
    `CHK("timeout", 1'b1, (jmp_t - t0 > exp_to - 7000) && (jmp_t - t0 < exp_to + 1000))
    `CHK("jump_addr", sbl_pkg::ADDR_RAM, jmp_a)
    `CHK("index_x", sbl_pkg::PROG_COUNT_DEF, idx_x)
    `CHK("index_y", sbl_pkg::ADDR_EPROM, idx_y)
    `CHK("writes", 2, wr_a.size())
    $display("load test done");
  endtask
  task automatic test_program;
    logic [7:0] dat[2];
    dat = '{8'h96, 8'h0F};
    wr_a.delete();
    wr_d.delete();
    sbl_host_model_inst.rx_q.delete();
    prog_override <= 1'b1;
    prog_time <= 16'h0008;
    prog_addr <= 16'hD100;
    run_program <= 1'b1;
    wait_rx(1);
    `CHK("ready", sbl_pkg::CHAR_SYNC, sbl_host_model_inst.rx_q[0])
    // two bytes up front keep one waiting in the receiver
    sbl_host_model_inst.send_byte(dat[0]);
    sbl_host_model_inst.send_byte(dat[1]);
    wait_rx(3);
    foreach (dat[k]) begin
      `CHK("prog_addr", 16'hD100 + 16'(k), wr_a[k])
      `CHK("prog_data", dat[k], wr_d[k])
      `CHK("verify", 8'(k) ^ 8'h5A, sbl_host_model_inst.rx_q[k + 1])
    end
    run_program <= 1'b0;
    prog_override <= 1'b0;
    do_reset();
    `CHK("writes_after_reset", 0, wr_a.size())
    $display("program test done");
  endtask
  task automatic test_upload;
    sbl_host_model_inst.send_byte(8'h00);
    for (int i = 0; i < 20000 && jmp_n == 0; i++) @(posedge i_clock);
    `CHK("upload_entry", sbl_pkg::ADDR_EEPROM, jmp_a)
    sbl_host_model_inst.rx_q.delete();
    user_addr <= 16'h0123;
    user_valid <= 1'b1;
    run_upload <= 1'b1;
    wait_rx(2);
    `CHK("upload_0", 8'h23 ^ 8'h5A, sbl_host_model_inst.rx_q[0])
    `CHK("upload_1", 8'h24 ^ 8'h5A, sbl_host_model_inst.rx_q[1])
    $display("upload test done");
  endtask
  initial begin
    i_reset_n = 1'b0;
    run_program = 1'b0;
    run_upload = 1'b0;
    user_valid = 1'b0;
    user_addr = 16'h0000;
    prog_override = 1'b0;
    prog_time = 16'h0000;
    prog_addr = 16'h0000;
    mem_rdata = 8'h00;
    test_eeprom_jump();
    test_slow_rate();
    test_load();
    test_program();
    test_upload();
    tally_and_finish();
  end
  initial begin
    repeat (4000000) @(posedge i_clock);
    failures++;
    tally_and_finish();
  end
endmodule
